// File: hdl/omc_mode_ctrl.sv
// operating mode control: reset self-test, mode state and address limits
//
// How it works
// RULE1: reset runs register test and init, then handover
// RULE2: every reset leaves the core in real mode
// RULE3: writing protection-enable one enters protected mode
// RULE4: protected mode enables full 32-bit instruction set
// RULE5: virtual_mode_flag lives at flags bit 17
// RULE6: flag set in protected mode enters virtual
// RULE7: flag cleared returns virtual to protected mode
// RULE8: virtual mode reachable only from protected mode
// RULE9: virtual/protected moves need no reset or init
// RULE10: real mode keeps addresses below 1 Mbyte untranslated
// RULE11: real and virtual modes enforce 1 Mbyte limit
// RULE12: real/virtual modes disable segmentation and paging
// RULE13: real/virtual addresses are linear and direct
// RULE14: mode derives from protection bit and flag
`timescale 1ns/1ps

module omc_mode_ctrl #(
    parameter int NUM_REGS = omc_pkg::NUM_INT_REGS
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ctrl_wr_in,
    input wire logic [omc_pkg::WORD_W-1:0] ctrl_data_in,
    input wire logic flags_wr_in,
    input wire logic [omc_pkg::WORD_W-1:0] flags_data_in,
    input wire logic reg_wr_in,
    input wire logic [$clog2(NUM_REGS)-1:0] reg_idx_in,
    input wire logic [omc_pkg::WORD_W-1:0] reg_data_in,
    input wire logic addr_valid_in,
    input wire logic [omc_pkg::WORD_W-1:0] addr_in,
    output omc_pkg::omc_mode_e mode_out,
    output logic [omc_pkg::WORD_W-1:0] machine_control_word_out,
    output logic [omc_pkg::WORD_W-1:0] processor_flags_word_out,
    output logic [omc_pkg::WORD_W-1:0] reg_data_out,
    output logic power_on_self_test_busy_out,
    output logic self_test_fail_out,
    output logic handover_out,
    output logic running_out,
    output logic full_isa_en_out,
    output logic mem_mgmt_en_out,
    output logic addr_valid_out,
    output logic [omc_pkg::WORD_W-1:0] addr_out,
    output logic addr_limit_fault_out
);
    import omc_pkg::*;

    localparam int IDX_W = $clog2(NUM_REGS);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NUM_REGS - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // self-test walk and the register array it exercises
        omc_phase_e phase;
        logic [IDX_W-1:0] idx;
        logic [NUM_REGS-1:0][WORD_W-1:0] regs;
        // software-visible words and the mode derived from them
        logic [WORD_W-1:0] ctrl;
        logic [WORD_W-1:0] flags;
        omc_mode_e mode;
        // registered outputs of the read port, self-test and address path
        logic [WORD_W-1:0] rd_data;
        logic fail;
        logic handover;
        logic addr_valid;
        logic [WORD_W-1:0] addr;
        logic fault;
    } omc_state_s;

    omc_state_s st;
    omc_state_s next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // pattern differs per register so stuck or shorted words show up
    function automatic logic [WORD_W-1:0] test_word(
        input logic [IDX_W-1:0] i
    );
        test_word = TEST_PATTERN ^ WORD_W'(i);
    endfunction

    function automatic omc_mode_e mode_of(
        input logic [WORD_W-1:0] ctrl,
        input logic [WORD_W-1:0] flags
    );
        if (!ctrl[PE_BIT]) begin
            mode_of = OMC_REAL;
        end else if (flags[VIRT_FLAG_BIT]) begin
            mode_of = OMC_VIRT;
        end else begin
            mode_of = OMC_PROT;
        end
    endfunction

    // the core's writes and address requests count only in run phase
    function automatic logic in_run(
        input omc_phase_e phase
    );
        in_run = (phase == OMC_RUN);
    endfunction

    // real and virtual mode share the 1 Mbyte window and lose the mmu
    function automatic logic is_low_mode(
        input omc_mode_e mode
    );
        is_low_mode = (mode != OMC_PROT);
    endfunction

    // zero-extended low window: no segment or page stage in the path
    function automatic logic [WORD_W-1:0] low_addr(
        input logic [WORD_W-1:0] addr
    );
        low_addr = {{(WORD_W-LOW_ADDR_W){1'b0}}, addr[LOW_ADDR_W-1:0]};
    endfunction

    function automatic logic over_limit(
        input logic [WORD_W-1:0] addr
    );
        over_limit = |addr[WORD_W-1:LOW_ADDR_W];
    endfunction

    // the index wraps to zero so the next phase starts at register 0
    function automatic logic [IDX_W-1:0] step_idx(
        input logic [IDX_W-1:0] i
    );
        if (i == LAST_IDX) begin
            step_idx = '0;
        end else begin
            step_idx = i + 1'b1;
        end
    endfunction

    // compared one bit wider so a power-of-two count does not wrap
    function automatic logic idx_in_range(
        input logic [IDX_W-1:0] i
    );
        idx_in_range = ({1'b0, i} < (IDX_W+1)'(NUM_REGS));
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // one process computes the whole next state; reset is applied last
    // so that it overrides every phase and every control and flags write
    always_comb begin
        logic [WORD_W-1:0] new_ctrl;
        logic [WORD_W-1:0] new_flags;
        logic low_mode;
        new_ctrl = st.ctrl;
        new_flags = st.flags;
        low_mode = 1'b0;
        next_st = st;
        next_st.handover = 1'b0;

        // self-test walk: write and read back each register, then clear
        // each one, then one handover cycle; 3*NUM_REGS+1 edges in all
        // RULE1: test then init internal registers
        unique case (st.phase)
            OMC_TEST_WR: begin
                next_st.regs[st.idx] = test_word(st.idx);
                next_st.phase = OMC_TEST_RD;
            end
            OMC_TEST_RD: begin
                if (st.regs[st.idx] != test_word(st.idx)) begin
                    next_st.fail = 1'b1;
                end
                next_st.idx = step_idx(st.idx);
                if (st.idx == LAST_IDX) begin
                    next_st.phase = OMC_INIT;
                end else begin
                    next_st.phase = OMC_TEST_WR;
                end
            end
            OMC_INIT: begin
                next_st.regs[st.idx] = REG_INIT_VAL;
                next_st.idx = step_idx(st.idx);
                if (st.idx == LAST_IDX) begin
                    next_st.phase = OMC_HANDOVER;
                end
            end
            // RULE1: one-cycle handover to external startup code
            OMC_HANDOVER: begin
                next_st.handover = 1'b1;
                next_st.phase = OMC_RUN;
            end
            OMC_RUN: begin
                if (reg_wr_in && idx_in_range(reg_idx_in)) begin
                    next_st.regs[reg_idx_in] = reg_data_in;
                end
                // RULE3: protection-enable write leaves real mode
                if (ctrl_wr_in) begin
                    new_ctrl = ctrl_data_in;
                end
                if (flags_wr_in) begin
                    new_flags = flags_data_in | FLAGS_FIXED_ONE;
                end
                // the flag is resolved against the new control word and the current mode, so
                // a joint write from real mode stops in protected mode
                // RULE8: flag cannot be set without protection
                // RULE14: flag ignored while protection is off
                if (!new_ctrl[PE_BIT] ||
                    (st.mode == OMC_REAL && !flags_wr_in)) begin
                    new_flags[VIRT_FLAG_BIT] = new_ctrl[PE_BIT] &
                                        st.flags[VIRT_FLAG_BIT];
                end
                if (st.mode == OMC_REAL && new_flags[VIRT_FLAG_BIT]) begin
                    new_flags[VIRT_FLAG_BIT] = 1'b0;
                end
                next_st.ctrl = new_ctrl;
                // RULE5: flag kept at its own bit of the flags word
                next_st.flags = new_flags;
                // RULE6: flag set while protected enters virtual
                // RULE7: flag cleared drops back to protected
                // RULE9: no reset path between those two modes
                next_st.mode = mode_of(new_ctrl, new_flags);
            end
            // three phase codes are unused; a stray one restarts the test
            default: begin
                next_st.phase = OMC_TEST_WR;
                next_st.idx = '0;
            end
        endcase

        // ------------------------------------------------------------
        // read port
        // ------------------------------------------------------------
        // the read shows the word before a same-cycle write lands
        if (idx_in_range(reg_idx_in)) begin
            next_st.rd_data = st.regs[reg_idx_in];
        end else begin
            next_st.rd_data = '0;
        end

        // ------------------------------------------------------------
        // address path
        // ------------------------------------------------------------
        // RULE11: 1 Mbyte ceiling in real and virtual mode
        low_mode = is_low_mode(st.mode);
        next_st.addr_valid = addr_valid_in && in_run(st.phase);
        if (low_mode) begin
            // RULE10: real addresses pass untranslated
            // RULE13: linear and direct, no mapping stage
            next_st.addr = low_addr(addr_in);
            next_st.fault = addr_valid_in && in_run(st.phase) &&
                            over_limit(addr_in);
        end else begin
            next_st.addr = addr_in;
            next_st.fault = 1'b0;
        end

        // ------------------------------------------------------------
        // reset
        // ------------------------------------------------------------
        // RULE2: reset always restarts in real mode
        if (!rst_n_in) begin
            next_st.phase = OMC_TEST_WR;
            next_st.idx = '0;
            next_st.ctrl = CTRL_WORD_RST;
            next_st.flags = FLAGS_WORD_RST;
            next_st.mode = OMC_REAL;
            next_st.fail = 1'b0;
            next_st.handover = 1'b0;
            next_st.rd_data = '0;
            next_st.addr_valid = 1'b0;
            next_st.addr = '0;
            next_st.fault = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // synchronous reset lives in the next-state logic; the register
    // array has no reset of its own since the self-test rewrites it
    always_ff @(posedge core_clk_in) begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mode_out = st.mode;
    assign machine_control_word_out = st.ctrl;
    assign processor_flags_word_out = st.flags;
    assign reg_data_out = st.rd_data;
    // busy and running are complements of one phase decode
    assign power_on_self_test_busy_out = !in_run(st.phase);
    assign self_test_fail_out = st.fail;
    // handover rises on the same edge that enters the run phase
    assign handover_out = st.handover;
    assign running_out = in_run(st.phase);
    // RULE4: full instruction set only when protected
    assign full_isa_en_out = !is_low_mode(st.mode);
    // RULE12: segmentation and paging off in low modes
    assign mem_mgmt_en_out = !is_low_mode(st.mode);
    assign addr_valid_out = st.addr_valid;
    assign addr_out = st.addr;
    assign addr_limit_fault_out = st.fault;

endmodule

// File: hdl/omc_pkg.sv
// constants and types shared by the operating mode control block
package omc_pkg;

    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 32;
    // protection-enable bit of the machine control word
    localparam int PE_BIT = 0;
    // virtual_mode_flag position in the processor flags word
    localparam int VIRT_FLAG_BIT = 17;
    // addresses at or above this bit are outside the 1 Mbyte window
    localparam int LOW_ADDR_W = 20;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_WORD_RST = 32'h0000_0000;
    // bit 1 of the flags word always reads as one
    localparam logic [31:0] FLAGS_WORD_RST = 32'h0000_0002;
    localparam logic [31:0] FLAGS_FIXED_ONE = 32'h0000_0002;
    localparam logic [31:0] REG_INIT_VAL = 32'h0000_0000;
    localparam logic [31:0] TEST_PATTERN = 32'ha5a5_5a5a;

    // ------------------------------------------------------------
    // counts
    // ------------------------------------------------------------
    localparam int NUM_INT_REGS = 16;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OMC_REAL,
        OMC_PROT,
        OMC_VIRT
    } omc_mode_e;

    typedef enum logic [2:0] {
        OMC_TEST_WR,
        OMC_TEST_RD,
        OMC_INIT,
        OMC_HANDOVER,
        OMC_RUN
    } omc_phase_e;

endpackage

// File: sim/omc_mode_ctrl_assertions.sv
// assertions on the mode, flag and address ports of the mode control
`timescale 1ns/1ps
module omc_mode_ctrl_assertions
    import omc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ctrl_wr_in,
    input wire logic [omc_pkg::WORD_W-1:0] ctrl_data_in,
    input wire logic flags_wr_in,
    input wire logic [omc_pkg::WORD_W-1:0] flags_data_in,
    input wire logic addr_valid_in,
    input wire logic [omc_pkg::WORD_W-1:0] addr_in,
    input omc_pkg::omc_mode_e mode_out,
    input wire logic [omc_pkg::WORD_W-1:0] processor_flags_word_out,
    input wire logic handover_out,
    input wire logic running_out,
    input wire logic full_isa_en_out,
    input wire logic mem_mgmt_en_out,
    input wire logic addr_valid_out,
    input wire logic [omc_pkg::WORD_W-1:0] addr_out,
    input wire logic addr_limit_fault_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic run_wr = running_out && !ctrl_wr_in && flags_wr_in;
    a_reset_real_mode: assert property ($rose(rst_n_in) |->
        mode_out == OMC_REAL) else $error("mode not real after reset");
    // counts fit the bench's two-register self-test: seven busy edges
    a_selftest_handover: assert property ($rose(rst_n_in) |->
        !running_out[*7] ##1 (handover_out && running_out) ##1
        (running_out && !handover_out))
        else $error("self-test handover out of time");
    a_ignore_before_run: assert property (!running_out |=>
        $stable(mode_out)) else $error("mode moved before run phase");
    a_enter_prot: assert property (running_out && ctrl_wr_in &&
        ctrl_data_in[0] |=> mode_out != OMC_REAL) else $error("no exit");
    a_pe_clear_real: assert property (running_out && ctrl_wr_in &&
        !ctrl_data_in[0] |=> mode_out == OMC_REAL) else $error("not real");
    a_enter_virt: assert property (run_wr && mode_out == OMC_PROT &&
        flags_data_in[17] |=> mode_out == OMC_VIRT) else $error("no virt");
    a_leave_virt: assert property (run_wr && mode_out == OMC_VIRT &&
        !flags_data_in[17] |=> mode_out == OMC_PROT) else $error("no prot");
    a_no_real_virt: assert property (mode_out == OMC_REAL |=>
        mode_out != OMC_VIRT) else $error("virtual entered from real");
    a_flag_tracks: assert property (processor_flags_word_out[17] ==
        (mode_out == OMC_VIRT)) else $error("flag bit and mode disagree");
    a_prot_features: assert property ((full_isa_en_out &&
        mem_mgmt_en_out) == (mode_out == OMC_PROT)) else $error("features");
    a_low_addr: assert property (running_out && addr_valid_in &&
        mode_out != OMC_PROT |=> addr_valid_out && addr_out ==
        {12'h000, $past(addr_in[19:0])} && addr_limit_fault_out ==
        ($past(addr_in[31:20]) != 12'h000)) else $error("low mode address");
    a_prot_addr: assert property (running_out && addr_valid_in &&
        mode_out == OMC_PROT |=> addr_out == $past(addr_in) &&
        !addr_limit_fault_out) else $error("protected address changed");
endmodule
bind omc_mode_ctrl omc_mode_ctrl_assertions chk_i (.core_clk_in, .rst_n_in,
    .ctrl_wr_in, .ctrl_data_in, .flags_wr_in, .flags_data_in, .addr_valid_in,
    .addr_in, .mode_out, .processor_flags_word_out, .handover_out,
    .running_out, .full_isa_en_out, .mem_mgmt_en_out, .addr_valid_out,
    .addr_out, .addr_limit_fault_out);

// File: sim/omc_mode_ctrl_tb_top.sv
// self-checking bench for the operating mode control block
`timescale 1ns/1ps
module omc_mode_ctrl_tb_top;
    import omc_pkg::*;
    logic core_clk_in = 1'h0, rst_n_in = 1'h0, ctrl_wr_in = 1'h0;
    logic flags_wr_in = 1'h0, reg_wr_in = 1'h0, addr_valid_in = 1'h0;
    logic [0:0] reg_idx_in = 1'h0;
    logic [31:0] ctrl_data_in = 32'h0, flags_data_in = 32'h0;
    logic [31:0] reg_data_in = 32'h0, addr_in = 32'h0;
    omc_mode_e mode_out;
    logic [31:0] machine_control_word_out, processor_flags_word_out;
    logic [31:0] reg_data_out, addr_out;
    logic power_on_self_test_busy_out, self_test_fail_out, handover_out;
    logic running_out, full_isa_en_out, mem_mgmt_en_out, addr_valid_out;
    logic addr_limit_fault_out;
    int failures = 0, comparisons = 0, cyc = 0;
    // two registers keep the self-test short
    omc_mode_ctrl #(.NUM_REGS(2)) omc_mode_ctrl_i (.*);
    always #25 core_clk_in = ~core_clk_in;
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 1000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic wr(input logic c, f, input logic [31:0] cd, fd);
        @(negedge core_clk_in);
        ctrl_wr_in = c;
        flags_wr_in = f;
        ctrl_data_in = cd;
        flags_data_in = fd;
        @(negedge core_clk_in);
        ctrl_wr_in = 1'h0;
        flags_wr_in = 1'h0;
    endtask
    task automatic reset_run();
        int n;
        rst_n_in = 1'h0;
        repeat (6) @(negedge core_clk_in);
        rst_n_in = 1'h1;
        // a write during the self-test must be dropped
        wr(1'h1, 1'h0, 32'h1, 32'h0);
        chk("busy", power_on_self_test_busy_out, 1'h1);
        n = 0;
        while (running_out !== 1'h1 && n < 40) begin
            @(negedge core_clk_in);
            n++;
        end
        chk("run", running_out, 1'h1);
        chk("handover", handover_out, 1'h1);
        chk("fail", self_test_fail_out, 1'h0);
        chk("mode", mode_out, OMC_REAL);
        chk("flags", processor_flags_word_out, FLAGS_WORD_RST);
    endtask
    task automatic t_modes();
        wr(1'h1, 1'h0, 32'h1, 32'h0);
        chk("mode", mode_out, OMC_PROT);
        chk("ctrl", machine_control_word_out, 32'h1);
        chk("isa", full_isa_en_out, 1'h1);
        wr(1'h0, 1'h1, 32'h0, 32'h0002_0000);
        chk("mode", mode_out, OMC_VIRT);
        chk("flags", processor_flags_word_out, 32'h0002_0002);
        chk("mmu", mem_mgmt_en_out, 1'h0);
        wr(1'h0, 1'h1, 32'h0, 32'h0);
        chk("mode", mode_out, OMC_PROT);
        chk("busy", power_on_self_test_busy_out, 1'h0);
        wr(1'h0, 1'h1, 32'h0, 32'h0002_0000);
        wr(1'h1, 1'h0, 32'h0, 32'h0);
        chk("mode", mode_out, OMC_REAL);
        chk("flags", processor_flags_word_out, 32'h2);
        wr(1'h0, 1'h1, 32'h0, 32'h0002_0000);
        chk("mode", mode_out, OMC_REAL);
        wr(1'h1, 1'h1, 32'h1, 32'h0002_0000);
        chk("mode", mode_out, OMC_PROT);
    endtask
    task automatic ad(input logic [31:0] a, ea, input logic ef);
        @(negedge core_clk_in);
        addr_valid_in = 1'h1;
        addr_in = a;
        @(negedge core_clk_in);
        addr_valid_in = 1'h0;
        chk("valid", addr_valid_out, 1'h1);
        chk("addr", addr_out, ea);
        chk("fault", addr_limit_fault_out, ef);
    endtask
    task automatic t_addr();
        ad(32'h0010_0004, 32'h0010_0004, 1'h0);
        wr(1'h1, 1'h0, 32'h0, 32'h0);
        ad(32'h0010_0004, 32'h0000_0004, 1'h1);
        ad(32'h000f_fffc, 32'h000f_fffc, 1'h0);
        wr(1'h1, 1'h0, 32'h1, 32'h0);
        wr(1'h0, 1'h1, 32'h0, 32'h0002_0000);
        ad(32'hffff_0010, 32'h000f_0010, 1'h1);
    endtask
    task automatic t_regs();
        @(negedge core_clk_in);
        reg_idx_in = 1'h1;
        @(negedge core_clk_in);
        chk("reg", reg_data_out, REG_INIT_VAL);
        reg_wr_in = 1'h1;
        reg_data_in = 32'h1234_5678;
        @(negedge core_clk_in);
        reg_wr_in = 1'h0;
        @(negedge core_clk_in);
        chk("reg", reg_data_out, 32'h1234_5678);
    endtask
    initial begin
        reset_run();
        t_modes();
        t_regs();
        t_addr();
        reset_run();
        report_and_stop();
    end
endmodule
